// [src/cful_flags.sv]
// condition_code_register with its update, wait release and register port
`timescale 1ns/1ps
// What this block does
// RULE1: half-carry takes carry out of bit 3
// RULE2: carry takes carry out of bit 7
// RULE3: negative is sign bit, zero on zero byte
// RULE4: per-flag code: test, clear, set, keep
// RULE5: overflow set when result equals 80 hex
// RULE6: decimal adjust sets carry, never clears it
// RULE7: overflow set when operand was 80 hex
// RULE8: overflow set when operand was 7F hex
// RULE9: shift overflow is negative xor carry
// RULE10: index compare negative from high byte sign
// RULE11: index compare overflow from high byte subtract
// RULE12: word loads take negative from bit 15
// RULE13: return_from_interrupt reloads all flags from stack
// RULE14: interrupt sets mask; masked wait needs non-maskable
// RULE15: transfer from accumulator A loads all flags
// RULE16: flags H I N Z V C in bits 5..0
module cful_flags
	import cful_pkg::*;
(
	input wire logic clk_i, // core clock
	input wire logic rst_b_i, // synchronous reset, active low
	input wire cful_pkg::cful_op_t op_i, // instruction flag request
	input wire cful_pkg::cful_alu_t alu_i, // datapath values for the tests
	input wire logic irq_taken_i, // interrupt entry, one cycle
	input wire logic irq_req_i, // maskable interrupt pending
	input wire logic nmi_req_i, // non-maskable interrupt pending
	input wire logic [cful_pkg::CFUL_ADDR_W-1:0] addr_i, // register address
	input wire logic [cful_pkg::CFUL_DATA_W-1:0] wdata_i, // register write data
	input wire logic wr_i, // register write strobe
	input wire logic rd_i, // register read strobe
	output logic [cful_pkg::CFUL_DATA_W-1:0] rdata_o, // read data, cycle after strobe
	output logic [5:0] flags_o, // condition_code_register contents
	output logic waiting_o, // held in wait_for_interrupt
	output logic wake_o // one-cycle wait release
);
	import cful_pkg::*;

	logic [5:0] flags_q;
	logic [5:0] flags_d;
	logic [5:0] alu_d;
	logic [5:0] test;
	logic dadj_c;
	logic waiting_q;
	logic wake_q;
	logic wake_d;
	logic enter_wait;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	function automatic logic apply_code(input cful_code_t code, input logic cur, input logic tst);
		logic r;
		case (code)
			CFUL_KEEP: r = cur;
			CFUL_CLR: r = 1'b0;
			CFUL_SET: r = 1'b1;
			CFUL_TEST: r = tst;
			default: r = cur;
		endcase
		return r;
	endfunction

	// RULE6: decimal adjust carry
	cful_dadj u_dadj (
		.acc_i(alu_i.opd),
		.half_i(flags_q[CFUL_BIT_H]),
		.carry_i(flags_q[CFUL_BIT_C]),
		.carry_o(dadj_c)
	);

	cful_flag_eval u_eval (
		.op_i(op_i),
		.alu_i(alu_i),
		.flags_i(flags_q),
		.dadj_c_i(dadj_c),
		.test_o(test)
	);

	genvar g;
	generate
		for (g = 0; g < CFUL_NFLAGS; g++)
		begin : g_flag
			// RULE4: per-flag update code
			assign alu_d[g] = apply_code(op_i.code[g], flags_q[g], test[g]);
		end
	endgenerate

	// software write lowest, instruction next, interrupt mask set on top
	always_comb
	begin
		flags_d = flags_q;
		if (wr_i && (addr_i == CFUL_REG_FLAGS))
		begin
			flags_d = wdata_i[5:0];
		end
		if (op_i.valid)
		begin
			case (op_i.kind)
				CFUL_K_ALU: flags_d = alu_d;
				// RULE13: reload from stacked copy
				CFUL_K_RESTORE: flags_d = alu_i.stacked[5:0];
				// RULE15: copy accumulator A
				CFUL_K_FROM_ACC: flags_d = alu_i.acc_a[5:0];
				CFUL_K_WAIT: flags_d = flags_q;
				default: flags_d = flags_q;
			endcase
		end
		// RULE14: interrupt entry sets mask, wins over any clear
		if (irq_taken_i)
		begin
			flags_d[CFUL_BIT_I] = 1'b1;
		end
	end

	// RULE16: fixed bit layout
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			flags_q <= CFUL_FLAGS_RST;
		else
			flags_q <= flags_d;
	end

	assign enter_wait = op_i.valid && (op_i.kind == CFUL_K_WAIT);
	// RULE14: masked wait only released by non-maskable
	assign wake_d = waiting_q && (nmi_req_i || (irq_req_i && !flags_q[CFUL_BIT_I]));

	// entering wins over a release in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			waiting_q <= 1'b0;
		else if (enter_wait)
			waiting_q <= 1'b1;
		else if (wake_d)
			waiting_q <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			wake_q <= 1'b0;
		else
			wake_q <= wake_d && !enter_wait;
	end

	always_comb
	begin
		rdata_d = 8'h00;
		if (rd_i)
		begin
			case (addr_i)
				CFUL_REG_FLAGS: rdata_d = {2'b00, flags_q};
				CFUL_REG_STATUS: rdata_d[CFUL_STAT_WAIT_BIT] = waiting_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// read data live for one cycle per strobe cycle, zero otherwise
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	assign rdata_o = rdata_q;
	assign flags_o = flags_q;
	assign waiting_o = waiting_q;
	assign wake_o = wake_q;

	logic alu_go;
	assign alu_go = op_i.valid && (op_i.kind == CFUL_K_ALU);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_half_carry: assert property ( // RULE1
		alu_go && op_i.code[CFUL_BIT_H] == CFUL_TEST |=> flags_q[CFUL_BIT_H] == $past(alu_i.c3))
		else $error("half-carry does not follow bit 3 carry");

	a_carry_out: assert property ( // RULE2
		alu_go && op_i.code[CFUL_BIT_C] == CFUL_TEST && op_i.csel == CFUL_C_CARRY
		|=> flags_q[CFUL_BIT_C] == $past(alu_i.c7))
		else $error("carry does not follow bit 7 carry");

	a_byte_nz: assert property ( // RULE3
		alu_go && op_i.width == CFUL_NZ_BYTE && op_i.code[CFUL_BIT_Z] == CFUL_TEST
		&& op_i.code[CFUL_BIT_N] == CFUL_TEST
		|=> flags_q[CFUL_BIT_Z] == ($past(alu_i.res[7:0]) == 8'h00) && flags_q[CFUL_BIT_N] == $past(alu_i.res[7]))
		else $error("negative or zero wrong for byte result");

	a_code_fixed: assert property ( // RULE4
		alu_go && op_i.code[CFUL_BIT_V] == CFUL_CLR && op_i.code[CFUL_BIT_C] == CFUL_SET
		|=> !flags_q[CFUL_BIT_V] && flags_q[CFUL_BIT_C])
		else $error("clear or set code not applied");

	a_code_keep: assert property ( // RULE4
		alu_go && op_i.code[CFUL_BIT_Z] == CFUL_KEEP && !(wr_i && addr_i == CFUL_REG_FLAGS)
		|=> $stable(flags_q[CFUL_BIT_Z]))
		else $error("not-affected flag changed");

	a_res_pattern: assert property ( // RULE5
		alu_go && op_i.code[CFUL_BIT_V] == CFUL_TEST && op_i.vsel == CFUL_V_RES80
		|=> flags_q[CFUL_BIT_V] == ($past(alu_i.res[7:0]) == 8'h80))
		else $error("result pattern overflow wrong");

	a_dadj_sticky: assert property ( // RULE6
		alu_go && op_i.code[CFUL_BIT_C] == CFUL_TEST && op_i.csel == CFUL_C_DADJ && flags_q[CFUL_BIT_C]
		|=> flags_q[CFUL_BIT_C])
		else $error("decimal adjust cleared a set carry");

	a_dadj_digit: assert property ( // RULE6
		alu_go && op_i.code[CFUL_BIT_C] == CFUL_TEST && op_i.csel == CFUL_C_DADJ && alu_i.opd[7:4] > 4'h9
		|=> flags_q[CFUL_BIT_C])
		else $error("decimal adjust missed upper digit carry");

	a_opd_pattern: assert property ( // RULE7
		alu_go && op_i.code[CFUL_BIT_V] == CFUL_TEST && op_i.vsel == CFUL_V_OPD80
		|=> flags_q[CFUL_BIT_V] == ($past(alu_i.opd) == 8'h80))
		else $error("operand pattern overflow wrong");

	a_inc_pattern: assert property ( // RULE8
		alu_go && op_i.code[CFUL_BIT_V] == CFUL_TEST && op_i.vsel == CFUL_V_OPD7F
		|=> flags_q[CFUL_BIT_V] == ($past(alu_i.opd) == 8'h7F))
		else $error("increment overflow wrong");

	a_shift_ovf: assert property ( // RULE9
		alu_go && op_i.vsel == CFUL_V_SHIFT && op_i.code[CFUL_BIT_V] == CFUL_TEST
		&& op_i.code[CFUL_BIT_N] == CFUL_TEST && op_i.code[CFUL_BIT_C] == CFUL_TEST
		|=> flags_q[CFUL_BIT_V] == (flags_q[CFUL_BIT_N] ^ flags_q[CFUL_BIT_C]))
		else $error("shift overflow is not negative xor carry");

	a_word_neg: assert property ( // RULE10 RULE12
		alu_go && op_i.width == CFUL_NZ_WORD && op_i.code[CFUL_BIT_N] == CFUL_TEST
		|=> flags_q[CFUL_BIT_N] == $past(alu_i.res[15]))
		else $error("word negative not from bit 15");

	a_idx_ovf: assert property ( // RULE11
		alu_go && op_i.vsel == CFUL_V_IDX && op_i.code[CFUL_BIT_V] == CFUL_TEST
		&& alu_i.opd[7] != alu_i.mem[7] && alu_i.res[15] == alu_i.mem[7]
		|=> flags_q[CFUL_BIT_V])
		else $error("index compare overflow missed");

	a_restore_all: assert property ( // RULE13
		op_i.valid && op_i.kind == CFUL_K_RESTORE && !irq_taken_i
		|=> flags_q == $past(alu_i.stacked[5:0]))
		else $error("restore did not reload all flags");

	a_irq_mask: assert property ( // RULE14
		irq_taken_i |=> flags_q[CFUL_BIT_I])
		else $error("interrupt entry left mask clear");

	a_masked_wait: assert property ( // RULE14
		waiting_q && flags_q[CFUL_BIT_I] && !nmi_req_i |=> !wake_q && waiting_q)
		else $error("masked wait released without non-maskable");

	a_from_acc: assert property ( // RULE15
		op_i.valid && op_i.kind == CFUL_K_FROM_ACC && !irq_taken_i
		|=> flags_q == $past(alu_i.acc_a[5:0]))
		else $error("transfer from accumulator wrong");

	a_zero_carry: assert property ( // RULE4
		alu_go && op_i.code[CFUL_BIT_C] == CFUL_TEST && op_i.csel == CFUL_C_RES_ZERO
		|=> flags_q[CFUL_BIT_C] == ($past(alu_i.res[7:0]) == 8'h00))
		else $error("zero-result carry test wrong");

	a_arith_ovf: assert property ( // RULE4
		alu_go && op_i.code[CFUL_BIT_V] == CFUL_TEST && op_i.vsel == CFUL_V_ARITH
		|=> flags_q[CFUL_BIT_V] == $past(alu_i.v7))
		else $error("arithmetic overflow not taken");

	a_flags_write: assert property ( // RULE16
		wr_i && addr_i == CFUL_REG_FLAGS && !op_i.valid && !irq_taken_i
		|=> flags_q == $past(wdata_i[5:0]))
		else $error("flags write did not land");

	a_flags_read: assert property ( // RULE16
		rd_i && addr_i == CFUL_REG_FLAGS |=> rdata_q == {2'b00, $past(flags_q)})
		else $error("flags read returned wrong bits");

	a_status_read: assert property ( // RULE14
		rd_i && addr_i == CFUL_REG_STATUS |=> rdata_q == {7'h00, $past(waiting_q)})
		else $error("status read returned wrong wait bit");

	a_wait_enter: assert property ( // RULE14
		enter_wait |=> waiting_q && !wake_q)
		else $error("wait not entered");

	a_nmi_release: assert property ( // RULE14
		waiting_q && nmi_req_i && !enter_wait |=> wake_q && !waiting_q)
		else $error("non-maskable did not release wait");

	a_irq_release: assert property ( // RULE14
		waiting_q && irq_req_i && !flags_q[CFUL_BIT_I] && !enter_wait
		|=> wake_q && !waiting_q)
		else $error("unmasked interrupt did not release wait");

	a_wake_single: assert property ( // RULE14
		wake_q |=> !wake_q)
		else $error("wake pulse longer than one cycle");
endmodule

// [inc/cful_pkg.sv]
// shared constants, enumerations and carriers of the condition flag update logic
package cful_pkg;

	localparam int unsigned CFUL_ADDR_W = 4;
	localparam int unsigned CFUL_DATA_W = 8;
	localparam int unsigned CFUL_NFLAGS = 6;

	// register offsets
	localparam logic [3:0] CFUL_REG_FLAGS = 4'h0;
	localparam logic [3:0] CFUL_REG_STATUS = 4'h1;
	localparam int unsigned CFUL_STAT_WAIT_BIT = 0;

	// flag positions inside the condition_code_register
	localparam int unsigned CFUL_BIT_C = 0;
	localparam int unsigned CFUL_BIT_V = 1;
	localparam int unsigned CFUL_BIT_Z = 2;
	localparam int unsigned CFUL_BIT_N = 3;
	localparam int unsigned CFUL_BIT_I = 4;
	localparam int unsigned CFUL_BIT_H = 5;

	localparam logic [5:0] CFUL_FLAGS_RST = 6'h00;

	// overflow test patterns
	localparam logic [7:0] CFUL_V_RES_PAT = 8'h80;
	localparam logic [7:0] CFUL_V_OPD_PAT = 8'h80;
	localparam logic [7:0] CFUL_V_INC_PAT = 8'h7F;

	// decimal digit limits
	localparam logic [3:0] CFUL_BCD_NINE = 4'h9;
	localparam logic [3:0] CFUL_BCD_EIGHT = 4'h8;

	typedef enum logic [1:0] {CFUL_KEEP, CFUL_CLR, CFUL_SET, CFUL_TEST} cful_code_t;
	typedef enum logic [1:0] {CFUL_K_ALU, CFUL_K_RESTORE, CFUL_K_FROM_ACC, CFUL_K_WAIT} cful_kind_t;
	typedef enum logic [2:0] {CFUL_V_ARITH, CFUL_V_RES80, CFUL_V_OPD80, CFUL_V_OPD7F, CFUL_V_SHIFT,
		CFUL_V_IDX} cful_vsel_t;
	typedef enum logic [1:0] {CFUL_C_CARRY, CFUL_C_RES_ZERO, CFUL_C_DADJ} cful_csel_t;
	typedef enum logic {CFUL_NZ_BYTE, CFUL_NZ_WORD} cful_width_t;

	// one instruction's flag request, indexed by flag position
	typedef struct packed {
		logic valid;
		cful_kind_t kind;
		cful_code_t [5:0] code;
		cful_vsel_t vsel;
		cful_csel_t csel;
		cful_width_t width;
	} cful_op_t;

	// datapath values that feed the flag tests
	typedef struct packed {
		logic [15:0] res;
		logic [7:0] opd;
		logic [7:0] mem;
		logic c3;
		logic c7;
		logic v7;
		logic [7:0] acc_a;
		logic [7:0] stacked;
	} cful_alu_t;

endpackage

// [src/cful_dadj.sv]
// carry evaluation for the decimal adjust step
`timescale 1ns/1ps
module cful_dadj
	import cful_pkg::*;
(
	input wire logic [7:0] acc_i, // accumulator before adjust
	input wire logic half_i, // current half-carry flag
	input wire logic carry_i, // current carry flag
	output logic carry_o // carry after adjust
);
	logic [3:0] lo;
	logic [3:0] hi;

	assign lo = acc_i[3:0];
	assign hi = acc_i[7:4];

	// RULE6: upper digit carry, old carry kept
	// upper digit overflows when it is above nine or tips over from a low-digit fix
	assign carry_o = carry_i | (hi > CFUL_BCD_NINE) | ((hi > CFUL_BCD_EIGHT) & ((lo > CFUL_BCD_NINE) | half_i));
endmodule

// [src/cful_flag_eval.sv]
// raw test values from the datapath for each flag except I, whose test value is its current state
`timescale 1ns/1ps
module cful_flag_eval
	import cful_pkg::*;
(
	input wire cful_op_t op_i, // flag request
	input wire cful_alu_t alu_i, // datapath values
	input wire logic [5:0] flags_i, // current flags
	input wire logic dadj_c_i, // decimal adjust carry
	output logic [5:0] test_o // test outcome per flag
);
	logic n_v;
	logic z_v;
	logic c_v;
	logic v_v;

	always_comb
	begin
		// RULE3 RULE10 RULE12: byte or word sign
		n_v = (op_i.width == CFUL_NZ_WORD) ? alu_i.res[15] : alu_i.res[7];
		z_v = (op_i.width == CFUL_NZ_WORD) ? (alu_i.res == 16'h0000) : (alu_i.res[7:0] == 8'h00);
		// RULE2: carry out of bit 7, or zero-result or decimal adjust carry as csel selects
		case (op_i.csel)
			CFUL_C_CARRY: c_v = alu_i.c7;
			CFUL_C_RES_ZERO: c_v = (alu_i.res[7:0] == 8'h00);
			CFUL_C_DADJ: c_v = dadj_c_i;
			default: c_v = alu_i.c7;
		endcase
		case (op_i.vsel)
			CFUL_V_ARITH: v_v = alu_i.v7;
			// RULE5: result pattern test
			CFUL_V_RES80: v_v = (alu_i.res[7:0] == CFUL_V_RES_PAT);
			// RULE7: operand pattern test
			CFUL_V_OPD80: v_v = (alu_i.opd == CFUL_V_OPD_PAT);
			// RULE8: increment pattern test
			CFUL_V_OPD7F: v_v = (alu_i.opd == CFUL_V_INC_PAT);
			// RULE9: post-shift values, not old flags
			CFUL_V_SHIFT: v_v = n_v ^ c_v;
			// RULE11: high-byte subtract, minuend in opd, subtrahend in mem
			CFUL_V_IDX: v_v = (alu_i.opd[7] & ~alu_i.mem[7] & ~alu_i.res[15]) |
				(~alu_i.opd[7] & alu_i.mem[7] & alu_i.res[15]);
			default: v_v = alu_i.v7;
		endcase
		test_o = flags_i;
		// RULE1: carry out of bit 3
		test_o[CFUL_BIT_H] = alu_i.c3;
		test_o[CFUL_BIT_N] = n_v;
		test_o[CFUL_BIT_Z] = z_v;
		test_o[CFUL_BIT_V] = v_v;
		test_o[CFUL_BIT_C] = c_v;
	end
endmodule

// [verif/cful_flags_tb.sv]
// self-checking bench for the condition_code_register update block
`timescale 1ns/1ps
module cful_flags_tb;
	import cful_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	cful_op_t op_i = '0;
	cful_alu_t alu_i = '0;
	logic irq_taken_i = 1'b0;
	logic irq_req_i = 1'b0;
	logic nmi_req_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic [5:0] flags_o;
	logic waiting_o;
	logic wake_o;
	int mismatches = 0;
	int num_checks = 0;
	cful_op_t o;
	cful_alu_t a;

	cful_flags cful_flags_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .op_i(op_i), .alu_i(alu_i),
		.irq_taken_i(irq_taken_i), .irq_req_i(irq_req_i), .nmi_req_i(nmi_req_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .flags_o(flags_o),
		.waiting_o(waiting_o), .wake_o(wake_o));

	always #25 clk_i = ~clk_i;

	task close_out;
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= ad;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task rd(input logic [3:0] ad, input logic [7:0] exp);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= ad;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask

	// flags of one request land on the edge that takes it
	task apply(input cful_op_t op, input cful_alu_t al, input logic [5:0] exp);
		@(posedge clk_i);
		op_i <= op;
		alu_i <= al;
		@(posedge clk_i);
		op_i.valid <= 1'b0;
		#1;
		chk({2'b00, flags_o}, {2'b00, exp});
	endtask

	function automatic cful_op_t mk(cful_kind_t k, cful_vsel_t v, cful_csel_t c, cful_width_t w);
		mk = '0;
		mk.valid = 1'b1;
		mk.kind = k;
		mk.vsel = v;
		mk.csel = c;
		mk.width = w;
	endfunction

	task t_regs;
		#1;
		chk({2'b00, flags_o}, 8'h00);
		wr(4'h0, 8'hFF);
		rd(4'h0, 8'h3F);
		rd(4'h1, 8'h00);
		wr(4'h7, 8'h00);
		rd(4'h7, 8'h00);
		rd(4'h0, 8'h3F);
	endtask

	task t_arith;
		wr(4'h0, 8'h00);
		o = mk(CFUL_K_ALU, CFUL_V_ARITH, CFUL_C_CARRY, CFUL_NZ_BYTE);
		o.code = '{CFUL_TEST, CFUL_KEEP, CFUL_TEST, CFUL_TEST, CFUL_TEST, CFUL_TEST};
		a = '0;
		a.c3 = 1'b1;
		a.c7 = 1'b1;
		a.v7 = 1'b1;
		a.res = 16'hFF00;
		apply(o, a, 6'h27);
		a = '0;
		a.res = 16'h0080;
		apply(o, a, 6'h08);
		wr(4'h0, 8'h12);
		o.code = '{CFUL_SET, CFUL_KEEP, CFUL_SET, CFUL_CLR, CFUL_KEEP, CFUL_SET};
		apply(o, a, 6'h3B);
		o.code = '{CFUL_CLR, CFUL_KEEP, CFUL_CLR, CFUL_CLR, CFUL_CLR, CFUL_SET};
		apply(o, a, 6'h11);
		o = mk(CFUL_K_ALU, CFUL_V_ARITH, CFUL_C_RES_ZERO, CFUL_NZ_BYTE);
		o.code[CFUL_BIT_C] = CFUL_TEST;
		a.res = 16'h0001;
		apply(o, a, 6'h10);
		a.res = 16'h0100;
		apply(o, a, 6'h11);
	endtask

	task t_vtests;
		cful_vsel_t vs [6] = '{CFUL_V_RES80, CFUL_V_RES80, CFUL_V_OPD80, CFUL_V_OPD80, CFUL_V_OPD7F, CFUL_V_OPD7F};
		logic [7:0] val [6] = '{8'h80, 8'h81, 8'h80, 8'h7F, 8'h7F, 8'h80};
		logic exp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		wr(4'h0, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			o = mk(CFUL_K_ALU, vs[i], CFUL_C_CARRY, CFUL_NZ_BYTE);
			o.code[CFUL_BIT_V] = CFUL_TEST;
			a = '0;
			a.res = {8'h00, val[i]};
			a.opd = val[i];
			apply(o, a, {4'h0, exp[i], 1'b0});
		end
	endtask

	task t_shift_word;
		o = mk(CFUL_K_ALU, CFUL_V_SHIFT, CFUL_C_CARRY, CFUL_NZ_BYTE);
		o.code = '{CFUL_KEEP, CFUL_KEEP, CFUL_TEST, CFUL_KEEP, CFUL_TEST, CFUL_TEST};
		a = '0;
		a.res = 16'h0080;
		apply(o, a, 6'h0A);
		a.c7 = 1'b1;
		apply(o, a, 6'h09);
		a.res = 16'h0001;
		apply(o, a, 6'h03);
		wr(4'h0, 8'h00);
		o = mk(CFUL_K_ALU, CFUL_V_ARITH, CFUL_C_CARRY, CFUL_NZ_WORD);
		o.code = '{CFUL_KEEP, CFUL_KEEP, CFUL_TEST, CFUL_TEST, CFUL_KEEP, CFUL_KEEP};
		a = '0;
		a.res = 16'h8000;
		apply(o, a, 6'h08);
		a.res = 16'h0100;
		apply(o, a, 6'h00);
		o = mk(CFUL_K_ALU, CFUL_V_IDX, CFUL_C_CARRY, CFUL_NZ_WORD);
		o.code = '{CFUL_KEEP, CFUL_KEEP, CFUL_TEST, CFUL_KEEP, CFUL_TEST, CFUL_KEEP};
		a.opd = 8'h80;
		a.mem = 8'h01;
		a.res = 16'h7FFF;
		apply(o, a, 6'h02);
		a.opd = 8'h10;
		a.mem = 8'h20;
		a.res = 16'hF000;
		apply(o, a, 6'h08);
	endtask

	task t_dadj;
		o = mk(CFUL_K_ALU, CFUL_V_ARITH, CFUL_C_DADJ, CFUL_NZ_BYTE);
		o.code[CFUL_BIT_C] = CFUL_TEST;
		a = '0;
		a.opd = 8'h45;
		wr(4'h0, 8'h00);
		apply(o, a, 6'h00);
		wr(4'h0, 8'h01);
		apply(o, a, 6'h01);
		wr(4'h0, 8'h20);
		a.opd = 8'h95;
		apply(o, a, 6'h21);
		wr(4'h0, 8'h00);
		a.opd = 8'h9A;
		apply(o, a, 6'h01);
		wr(4'h0, 8'h00);
		a.opd = 8'hA0;
		apply(o, a, 6'h01);
	endtask

	task t_load;
		a = '0;
		a.stacked = 8'hE5;
		a.acc_a = 8'h5A;
		apply(mk(CFUL_K_RESTORE, CFUL_V_ARITH, CFUL_C_CARRY, CFUL_NZ_BYTE), a, 6'h25);
		apply(mk(CFUL_K_FROM_ACC, CFUL_V_ARITH, CFUL_C_CARRY, CFUL_NZ_BYTE), a, 6'h1A);
	endtask

	// mask set wins over a clearing write in the same cycle
	task t_wait;
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= 4'h0;
		wdata_i <= 8'h00;
		irq_taken_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		irq_taken_i <= 1'b0;
		#1;
		chk({2'b00, flags_o}, 8'h10);
		a = '0;
		apply(mk(CFUL_K_WAIT, CFUL_V_ARITH, CFUL_C_CARRY, CFUL_NZ_BYTE), a, 6'h10);
		chk({7'h00, waiting_o}, 8'h01);
		@(posedge clk_i);
		irq_req_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		chk({6'h00, waiting_o, wake_o}, 8'h02);
		rd(4'h1, 8'h01);
		@(posedge clk_i);
		nmi_req_i <= 1'b1;
		irq_req_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk({6'h00, waiting_o, wake_o}, 8'h01);
		@(posedge clk_i);
		nmi_req_i <= 1'b0;
		#1;
		chk({6'h00, waiting_o, wake_o}, 8'h00);
		wr(4'h0, 8'h00);
		apply(mk(CFUL_K_WAIT, CFUL_V_ARITH, CFUL_C_CARRY, CFUL_NZ_BYTE), a, 6'h00);
		@(posedge clk_i);
		irq_req_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk({6'h00, waiting_o, wake_o}, 8'h01);
		irq_req_i <= 1'b0;
	endtask

	// reset in mid-run clears flags, mask and a pending wait
	task t_reset;
		wr(4'h0, 8'h3F);
		a = '0;
		apply(mk(CFUL_K_WAIT, CFUL_V_ARITH, CFUL_C_CARRY, CFUL_NZ_BYTE), a, 6'h3F);
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		#1;
		chk({2'b00, flags_o}, 8'h00);
		chk({6'h00, waiting_o, wake_o}, 8'h00);
		rd(4'h1, 8'h00);
	endtask

	// hang guard, far beyond the length of the sequence
	initial
	begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		close_out();
	end

	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_regs();
		t_arith();
		t_vtests();
		t_shift_word();
		t_dadj();
		t_load();
		t_wait();
		t_reset();
		close_out();
	end
endmodule
